// file: logic/brc_pkg.sv
package brc_pkg;

  // ****************************************
  // Register layout
  // ****************************************
  localparam int          CFG_W      = 16;
  localparam int          ADDR_LSB   = 2;      // Address line carrying bit 0
  localparam int          B_RSEL     = 15;
  localparam int          B_XLAT_HI  = 14;
  localparam int          B_XLAT_LO  = 11;
  localparam int          B_YLAT     = 9;
  localparam int          B_RDY      = 8;
  localparam int          B_ORDER    = 7;
  localparam int          B_EDGE     = 6;
  localparam int          B_LATCH    = 3;
  localparam int          B_LEN_HI   = 2;
  localparam int          B_LEN_LO   = 0;
  localparam logic [15:0] RSV_MASK   = 16'h0430; // Bits ten, five, four
  // Asynchronous, no latch read, latency code 0011, continuous length
  localparam logic [15:0] CFG_RESET  = 16'h9807;

  // ****************************************
  // Field codes and timing
  // ****************************************
  localparam logic [3:0]  XL_13C     = 4'hB;
  localparam logic [3:0]  XL_15      = 4'hD;
  localparam logic [2:0]  LEN_1      = 3'h4;
  localparam logic [2:0]  LEN_2      = 3'h5;
  localparam logic [2:0]  LEN_4      = 3'h1;
  localparam logic [2:0]  LEN_8      = 3'h2;
  localparam logic [2:0]  LEN_CONT   = 3'h7;
  localparam logic [4:0]  WAIT_CYC   = 5'h01;  // Extra wait states on page cross
  localparam logic [2:0]  PAGE_X16   = 3'h3;   // Four words per page
  localparam logic [2:0]  PAGE_X32   = 3'h1;   // Two double-words per page

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT  = 2'b01,
    ST_DATA = 2'b11,
    ST_WAIT = 2'b10
  } brc_state_e;

  // First access cycles per code; zero marks a reserved code
  function automatic logic [4:0] brc_xlat_cycles(input logic [3:0] code);
    case (code)
      4'h2:    brc_xlat_cycles = 5'h07;
      4'h3:    brc_xlat_cycles = 5'h08;
      4'h4:    brc_xlat_cycles = 5'h09;
      4'h5:    brc_xlat_cycles = 5'h0A;
      4'h6:    brc_xlat_cycles = 5'h0B;
      4'h9:    brc_xlat_cycles = 5'h0C;
      4'hA:    brc_xlat_cycles = 5'h0D;
      4'hB:    brc_xlat_cycles = 5'h0D;
      4'hD:    brc_xlat_cycles = 5'h0F;
      default: brc_xlat_cycles = 5'h00;
    endcase
  endfunction : brc_xlat_cycles

  // Wrap mask per length code; continuous uses the full offset
  function automatic logic [2:0] brc_len_mask(input logic [2:0] code);
    case (code)
      LEN_2:   brc_len_mask = 3'h1;
      LEN_4:   brc_len_mask = 3'h3;
      LEN_8:   brc_len_mask = 3'h7;
      LEN_CONT: brc_len_mask = 3'h7;
      default: brc_len_mask = 3'h0;
    endcase
  endfunction : brc_len_mask

endpackage : brc_pkg

// file: logic/brc_order_if.sv
`timescale 1ns/1ns
interface brc_order_if;
  logic [2:0] start;
  logic [2:0] idx;
  logic [2:0] mask;
  logic       seq;
  logic       cont;
  logic [2:0] offset;

  modport gen (input start, input idx, input mask, input seq, input cont, output offset);
  modport seqr (output start, output idx, output mask, output seq, output cont, input offset);
endinterface : brc_order_if

// file: logic/brc_order_gen.sv
`timescale 1ns/1ns
module brc_order_gen (
  brc_order_if.gen bo
);

  // ****************************************
  // Burst offset from start and beat index
  // ****************************************
  // Interleaved order is invalid for continuous, so continuous always counts up
  always_comb begin
    if (bo.cont) begin
      bo.offset = 3'(bo.start + bo.idx);
    end else if (bo.seq) begin
      bo.offset = (bo.start & ~bo.mask) | (3'(bo.start + bo.idx) & bo.mask);
    end else begin
      bo.offset = bo.start ^ (bo.idx & bo.mask);
    end
  end

endmodule : brc_order_gen

// file: logic/brc_config.sv
`timescale 1ns/1ns
module brc_config (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        pwr_down_b,
  input  wire logic        bus_wide32,
  input  wire logic        cmd_cfg_we,
  input  wire logic [17:2] cmd_cfg_addr,
  input  wire logic        burst_start,
  input  wire logic [2:0]  burst_start_offset,
  input  wire logic        burst_advance,
  input  wire logic        burst_abort,
  output logic             cfg_rejected,
  output logic             cfg_read_async,
  output logic             cfg_latch_read,
  output logic             cfg_edge_rising,
  output logic             beat_valid,
  output logic [2:0]       beat_offset,
  output logic             data_ready
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic                  pd_meta;
  logic                  pd_sync;
  logic                  wide_meta;
  logic                  wide_sync;

  // Power-down and width pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pd_meta   <= 1'b1;
      pd_sync   <= 1'b1;
      wide_meta <= 1'b0;
      wide_sync <= 1'b0;
    end else begin
      pd_meta   <= pwr_down_b;
      pd_sync   <= pd_meta;
      wide_meta <= bus_wide32;
      wide_sync <= wide_meta;
    end
  end

  // ****************************************
  // Configuration register
  // ****************************************
  logic [15:0]           cfg_q;
  logic [3:0]            wr_xcode;
  logic                  wr_ybit;
  logic                  cfg_ok;

  assign wr_xcode = cmd_cfg_addr[brc_pkg::B_XLAT_HI + brc_pkg::ADDR_LSB :
                                 brc_pkg::B_XLAT_LO + brc_pkg::ADDR_LSB];
  assign wr_ybit  = cmd_cfg_addr[brc_pkg::B_YLAT + brc_pkg::ADDR_LSB];

  assign cfg_ok = (brc_pkg::brc_xlat_cycles(wr_xcode) != 5'h00)
                && (brc_pkg::brc_len_mask(cmd_cfg_addr[4:2]) != 3'h0
                    || cmd_cfg_addr[4:2] == brc_pkg::LEN_1)
                && !(wr_ybit && (wr_xcode == brc_pkg::XL_13C
                                 || wr_xcode == brc_pkg::XL_15));

  // reset values
  // Rejecting the whole write keeps a half-valid setting from ever running
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !pd_sync) begin
      cfg_q <= brc_pkg::CFG_RESET;
    end else if (cmd_cfg_we && cfg_ok) begin
      cfg_q <= cmd_cfg_addr & ~brc_pkg::RSV_MASK;
    end
  end

  // One-cycle flag for a refused write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_rejected <= 1'b0;
    end else begin
      cfg_rejected <= cmd_cfg_we && !cfg_ok;
    end
  end

  assign cfg_read_async  = cfg_q[brc_pkg::B_RSEL];
  assign cfg_latch_read  = cfg_q[brc_pkg::B_LATCH];
  assign cfg_edge_rising = cfg_q[brc_pkg::B_EDGE];

  // ****************************************
  // Field decode
  // ****************************************
  logic [3:0]            xcode;
  logic [4:0]            xlat;
  logic                  y2;
  logic [2:0]            len_code;
  logic                  cont;
  logic [2:0]            page_mask;

  assign xcode     = cfg_q[brc_pkg::B_XLAT_HI:brc_pkg::B_XLAT_LO];
  assign xlat      = brc_pkg::brc_xlat_cycles(xcode);
  assign y2        = cfg_q[brc_pkg::B_YLAT] || xcode == brc_pkg::XL_13C
                     || xcode == brc_pkg::XL_15;
  assign len_code  = cfg_q[brc_pkg::B_LEN_HI:brc_pkg::B_LEN_LO];
  assign cont      = len_code == brc_pkg::LEN_CONT;
  assign page_mask = wide_sync ? brc_pkg::PAGE_X32 : brc_pkg::PAGE_X16;

  // ****************************************
  // Burst sequencer
  // ****************************************
  brc_pkg::brc_state_e   state;
  logic [4:0]            cnt;
  logic [2:0]            idx;
  logic [2:0]            start_q;
  logic                  y_phase;
  logic                  wait_pend;
  logic                  step;
  logic                  cross_pg;
  logic                  start_ok;
  logic [2:0]            next_idx;

  brc_order_if bo_if ();

  brc_order_gen u_gen (
    .bo (bo_if.gen)
  );

  assign bo_if.start = start_q;
  assign bo_if.idx   = idx;
  assign bo_if.mask  = brc_pkg::brc_len_mask(len_code);
  assign bo_if.seq   = cfg_q[brc_pkg::B_ORDER];
  assign bo_if.cont  = cont;

  assign start_ok = burst_start && !cfg_q[brc_pkg::B_RSEL];
  // second cycle of a two-cycle beat holds the data
  assign step     = state == brc_pkg::ST_DATA && burst_advance && (!y2 || y_phase);
  assign next_idx = 3'(idx + 3'h1);
  assign cross_pg = step && wait_pend
                    && ((3'(start_q + next_idx) & page_mask) == 3'h0);

  // State, counters and beat index
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !pd_sync || burst_abort) begin
      state     <= brc_pkg::ST_IDLE;
      cnt       <= 5'h00;
      idx       <= 3'h0;
      start_q   <= 3'h0;
      y_phase   <= 1'b0;
      wait_pend <= 1'b0;
    end else if (start_ok) begin
      state     <= brc_pkg::ST_LAT;
      cnt       <= xlat;
      idx       <= 3'h0;
      start_q   <= burst_start_offset;
      y_phase   <= 1'b0;
      wait_pend <= cont && ((burst_start_offset & page_mask) != 3'h0);
    end else begin
      unique case (state)
        brc_pkg::ST_IDLE: begin
          cnt <= 5'h00;
        end
        brc_pkg::ST_LAT: begin
          cnt <= 5'(cnt - 5'h01);
          // Output flops add one cycle, so leave one early
          if (cnt == 5'h02) begin
            state <= brc_pkg::ST_DATA;
          end
        end
        brc_pkg::ST_DATA: begin
          if (burst_advance) begin
            y_phase <= y2 && !y_phase;
          end
          if (step) begin
            idx <= next_idx;
          end
          if (cross_pg) begin
            state     <= brc_pkg::ST_WAIT;
            cnt       <= brc_pkg::WAIT_CYC;
            wait_pend <= 1'b0;
          end
        end
        brc_pkg::ST_WAIT: begin
          cnt <= 5'(cnt - 5'h01);
          if (cnt == 5'h01) begin
            state <= brc_pkg::ST_DATA;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  // ready timing select
  // Early mode looks at the page crossing one cycle ahead of the wait
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !pd_sync || burst_abort) begin
      beat_valid  <= 1'b0;
      beat_offset <= 3'h0;
      data_ready  <= 1'b0;
    end else begin
      beat_valid  <= state == brc_pkg::ST_DATA;
      beat_offset <= bo_if.offset;
      data_ready  <= state == brc_pkg::ST_DATA
                     && !(cfg_q[brc_pkg::B_RDY] && cross_pg);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  reset_values_a: assert property (disable iff (1'b0)
    !rst_b |=> cfg_read_async && !cfg_latch_read && cfg_q == brc_pkg::CFG_RESET)
    else $error("reset values wrong");

  cfg_hold_a: assert property (
    !cmd_cfg_we && pd_sync && $past(pd_sync) |=> $stable(cfg_q))
    else $error("configuration changed without a write");

  cfg_load_a: assert property (
    cmd_cfg_we && cfg_ok && pd_sync |=> cfg_read_async == $past(cmd_cfg_addr[17])
      && cfg_q[2:0] == $past(cmd_cfg_addr[4:2]) && cfg_q[14:11] == $past(cmd_cfg_addr[16:13]))
    else $error("field not loaded from address line");

  reserved_code_a: assert property (
    cmd_cfg_we && brc_pkg::brc_xlat_cycles(wr_xcode) == 5'h00 && pd_sync
      |=> $stable(cfg_q) && cfg_rejected)
    else $error("reserved latency code accepted");

  async_no_burst_a: assert property (
    burst_start && cfg_read_async && state == brc_pkg::ST_IDLE && !burst_abort
      |=> state == brc_pkg::ST_IDLE)
    else $error("burst started in asynchronous mode");

  first_data_a: assert property (
    start_ok && xcode == 4'h3 && !burst_abort && pd_sync
      ##1 (!burst_abort && !burst_start && pd_sync) [*8]
      |=> beat_valid && !$past(beat_valid))
    else $error("first data not after eight cycles");

  beat_hold_a: assert property (
    state == brc_pkg::ST_DATA && y2 && burst_advance && !y_phase && !burst_start
      && !burst_abort && pd_sync |=> $stable(idx))
    else $error("two-cycle beat advanced early");

  ready_same_a: assert property (
    !cfg_q[brc_pkg::B_RDY] |-> data_ready == beat_valid)
    else $error("ready differs from valid data");

  ready_early_a: assert property (
    cfg_q[brc_pkg::B_RDY] && beat_valid && !data_ready && !burst_abort
      && !burst_start && pd_sync |=> !beat_valid)
    else $error("early ready not followed by invalid data");

  interleave_a: assert property (
    beat_valid && !$past(beat_valid) && !bo_if.seq && len_code == brc_pkg::LEN_4
      && start_q == 3'h1 |-> beat_offset == 3'h1)
    else $error("interleaved first offset wrong");

  wrap_block_a: assert property (
    beat_valid && !cont |-> (beat_offset & ~bo_if.mask) == (start_q & ~bo_if.mask))
    else $error("burst left its wrap block");

  wait_ready_a: assert property (
    state == brc_pkg::ST_WAIT && !burst_abort && pd_sync |=> !data_ready && !beat_valid)
    else $error("ready high during wait state");

  sync_burst_c: cover property (start_ok ##[7:16] beat_valid);
  page_wait_c: cover property (state == brc_pkg::ST_WAIT);
  reject_c: cover property (cfg_rejected);
  two_cycle_c: cover property (beat_valid && y2 && step);

endmodule : brc_config

// file: dv/brc_host_model.sv
`timescale 1ns/1ns
// ****************************************
// Host controller on the flash bus
// ****************************************
module brc_host_model (
  input  wire logic        clk_sys,
  output logic             cmd_cfg_we,
  output logic [17:2]      cmd_cfg_addr,
  output logic             burst_start,
  output logic [2:0]       burst_start_offset,
  output logic             burst_advance,
  output logic             burst_abort
);
  // Idle bus; address lines never rest on the last value
  initial begin
    cmd_cfg_we         = 1'b0;
    cmd_cfg_addr       = 16'hFFFF;
    burst_start        = 1'b0;
    burst_start_offset = 3'h0;
    burst_advance      = 1'b0;
    burst_abort        = 1'b0;
  end

  // fields on address lines, reserved bits zero
  // wide bus only ever paired with latency codes legal there
  // reserved codes only when a scenario asks for them
  task automatic cfg_write(input logic [15:0] cfg);
    // Idle edge first, so back-to-back writes never move the strobe twice at once
    @(posedge clk_sys);
    #2;
    cmd_cfg_we   = 1'b1;
    cmd_cfg_addr = cfg & ~brc_pkg::RSV_MASK;
    @(posedge clk_sys);
    #2;
    cmd_cfg_we   = 1'b0;
    cmd_cfg_addr = ~cmd_cfg_addr;
  endtask : cfg_write

  // Address latch pulse, advance held so every beat steps
  task automatic start(input logic [2:0] off);
    burst_start_offset = off;
    burst_start        = 1'b1;
    burst_advance      = 1'b1;
    @(posedge clk_sys);
    #2;
    burst_start        = 1'b0;
    burst_start_offset = ~off;
  endtask : start

  // One-cycle abort, advance released with it
  task automatic abort();
    burst_abort   = 1'b1;
    burst_advance = 1'b0;
    @(posedge clk_sys);
    #2;
    burst_abort   = 1'b0;
  endtask : abort
endmodule : brc_host_model

// file: dv/burst_read_config_register_bench.sv
`timescale 1ns/1ns
module burst_read_config_register_bench;
  logic        clk_sys;
  logic        rst_b;
  logic        pwr_down_b;
  logic        bus_wide32;
  logic        cmd_cfg_we;
  logic [17:2] cmd_cfg_addr;
  logic        burst_start;
  logic [2:0]  burst_start_offset;
  logic        burst_advance;
  logic        burst_abort;
  logic        cfg_rejected;
  logic        cfg_read_async;
  logic        cfg_latch_read;
  logic        cfg_edge_rising;
  logic        beat_valid;
  logic [2:0]  beat_offset;
  logic        data_ready;
  int          failures;
  int          n_tests;
  logic [15:0] ok_lat;
  logic [7:0]  ok_len;

  brc_config dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .pwr_down_b(pwr_down_b), .bus_wide32(bus_wide32),
    .cmd_cfg_we(cmd_cfg_we), .cmd_cfg_addr(cmd_cfg_addr), .burst_start(burst_start),
    .burst_start_offset(burst_start_offset), .burst_advance(burst_advance),
    .burst_abort(burst_abort), .cfg_rejected(cfg_rejected), .cfg_read_async(cfg_read_async),
    .cfg_latch_read(cfg_latch_read), .cfg_edge_rising(cfg_edge_rising),
    .beat_valid(beat_valid), .beat_offset(beat_offset), .data_ready(data_ready)
  );

  brc_host_model host (
    .clk_sys(clk_sys), .cmd_cfg_we(cmd_cfg_we), .cmd_cfg_addr(cmd_cfg_addr),
    .burst_start(burst_start), .burst_start_offset(burst_start_offset),
    .burst_advance(burst_advance), .burst_abort(burst_abort)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // Config flags packed: rejected, async, latch, edge
  function automatic logic [3:0] flags();
    flags = {cfg_rejected, cfg_read_async, cfg_latch_read, cfg_edge_rising};
  endfunction : flags

  // Burst of four beats, each standing rep cycles, then abort
  task automatic burst(input logic [15:0] cfg, input logic [2:0] off, input int lat,
                       input logic [11:0] seq, input int rep);
    host.cfg_write(cfg);
    host.start(off);
    step(lat - 1);
    check({beat_valid, 3'h0}, 4'h0);
    for (int i = 0; i < 4; i++) begin
      repeat (rep) begin
        step(1);
        check({beat_valid & data_ready, beat_offset}, {1'b1, seq[11 - 3 * i -: 3]});
      end
    end
    host.abort();
    check({beat_valid, beat_offset}, 4'h0);
  endtask : burst

  // Continuous burst from offset one, latency eight: pre beats, one wait, then resume
  task automatic page_burst(input logic [15:0] cfg, input int pre, input logic early);
    host.cfg_write(cfg);
    host.start(3'h1);
    step(7);
    for (int i = 1; i <= pre; i++) begin
      step(1);
      check({beat_valid, beat_offset}, {1'b1, 3'(i)});
    end
    // Early ready timing drops ready on the last beat before the wait
    check({data_ready, 3'h0}, {~early, 3'h0});
    step(1);
    check({beat_valid, data_ready, 2'h0}, 4'h0);
    step(1);
    check({beat_valid & data_ready, beat_offset}, {1'b1, 3'(pre + 1)});
    host.abort();
  endtask : page_burst

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Watchdog well above the few hundred cycles of the run
  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures   = 0;
    n_tests    = 0;
    ok_lat     = 16'h2E7C;
    ok_len     = 8'hB6;
    rst_b      = 1'b0;
    pwr_down_b = 1'b1;
    bus_wide32 = 1'b0;
    step(8);
    rst_b = 1'b1;
    check(flags(), 4'h4);
    check({beat_valid, data_ready, 2'h0}, 4'h0);
    // Every latency code, async and continuous otherwise
    for (int c = 0; c < 16; c++) begin
      host.cfg_write({1'b1, 4'(c), 11'h007});
      check({cfg_rejected, 3'h0}, {~ok_lat[c], 3'h0});
    end
    // Every length code with latency eight
    for (int c = 0; c < 8; c++) begin
      host.cfg_write({1'b1, 4'h3, 8'h00, 3'(c)});
      check({cfg_rejected, 3'h0}, {~ok_len[c], 3'h0});
    end
    host.cfg_write(16'hDA07);
    check(flags(), 4'hC);
    // Latency eight and continuous length keep this latch-read write legal
    host.cfg_write(16'h980F);
    check(flags(), 4'h6);
    // Burst request while asynchronous must be ignored
    host.start(3'h0);
    step(10);
    check({beat_valid, data_ready, 2'h0}, 4'h0);
    step(20);
    check(flags(), 4'h6);
    burst(16'h1841, 3'h1, 8, 12'o1032, 1);
    check(flags(), 4'h1);
    burst(16'h18C1, 3'h1, 8, 12'o1230, 1);
    burst(16'h1A41, 3'h2, 8, 12'o2301, 2);
    burst(16'h4AC1, 3'h3, 12, 12'o3012, 2);
    burst(16'h68C1, 3'h0, 15, 12'o0123, 2);
    page_burst(16'h18C7, 3, 1'b0);
    page_burst(16'h19C7, 3, 1'b1);
    // Wide bus: two double-words per page; pin settles before the burst starts
    bus_wide32 = 1'b1;
    page_burst(16'h19C7, 1, 1'b1);
    host.cfg_write(16'h1841);
    pwr_down_b = 1'b0;
    step(4);
    pwr_down_b = 1'b1;
    step(3);
    check(flags(), 4'h4);
    give_verdict();
  end
endmodule : burst_read_config_register_bench
